// file: logic/mfp_pkg.sv
// package for the eight-pin multi-function configuration block (pins six to thirteen)
// assumes one 100 MHz clock, a plain strobe register port and a slow tick from the rtc side
//
// Operation
// - function field: 00 alternate, 01 input, 10 open-drain out, 11 push-pull out
// - type 0: input active low; output on supply one or internal pull-up
// - type 1: input active high; output on supply two or external pull-up
// - output mode bit sets driven level: 0 low, 1 high
// - input mode 0 bypasses debounce; mode 1 debounces and raises wake-up
// - enable and feedback pins in alternate function feed status register bits
// - pin eight polarity bit also applies to the system-enable function
// - pin eight mode 0: plain input, no debounce, no system-enable
// - pin nine mode bit sets power-enable debounce and wake-up
// - pins ten, eleven as outputs with type set blink from rtc counter
// - pin ten secondary enable mode 1: debounce, wake-up, 500 ms wait timeout
// - pin eleven accessory detect wakes only on float flag falling edge
// - pin twelve control input mode 0 drives regulator nine enable undebounced
// - pin twelve control input mode 1 debounced, no regulator control
// - pin twelve alternate is feedback/wake-up signal, supply follows type bit
// - pin thirteen alternate drives supply fault, supply one when type 0
package mfp_pkg;
  localparam logic [7:0] ADDR_CFG_67     = 8'h18;
  localparam logic [7:0] ADDR_CFG_89     = 8'h19;
  localparam logic [7:0] ADDR_CFG_1011   = 8'h1a;
  localparam logic [7:0] ADDR_CFG_1213   = 8'h1b;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_EVT_MASK   = 8'h1d;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h1e;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'hff;
  // per-pin nibble fields
  localparam int FLD_FUNC_LSB = 0;
  localparam int FLD_TYPE     = 2;
  localparam int FLD_MODE     = 3;
  localparam logic [1:0] FUNC_ALT   = 2'h0;
  localparam logic [1:0] FUNC_INPUT = 2'h1;
  localparam logic [1:0] FUNC_OD    = 2'h2;
  localparam logic [1:0] FUNC_PP    = 2'h3;
  // pin-status register bits
  localparam int ST_SYSTEM_ENABLE_INPUT  = 0;
  localparam int ST_POWER_ENABLE_INPUT  = 1;
  localparam int ST_SECONDARY_POWER_ENABLE_INPUT = 2;
  localparam int ST_FB1     = 3;
  localparam int ST_REG9_EN = 4;
  localparam int ST_WAIT_TO = 5;
  // event bit six, not the four held in EVT_PIN12, is the regulator-control pin twelve input change
  localparam int EVT_PIN12  = 4;
  localparam int DEB_TICKS  = 4;
  localparam logic [2:0] DEB_TICKS_W = 3'h4;
  localparam int CLK_MHZ         = 100;
  localparam int WAIT_TIMEOUT_MS = 500;
  localparam int WAIT_TIMEOUT_CYC = WAIT_TIMEOUT_MS * 1000 * CLK_MHZ;
endpackage

// file: logic/multi_function_pin_config.sv
// configuration and pin logic for multi-function pins six to thirteen
// assumes pins are asynchronous, rtc blink and slow tick are in clk_sys_i domain
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module multi_function_pin_config #(
  parameter int WAIT_TIMEOUT_CYC = mfp_pkg::WAIT_TIMEOUT_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] pin_in_i,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oe_n_o,
  output logic      [7:0] pin_supply_two_o,
  output logic      [7:0] pin_pullup_en_o,
  input  wire logic       slow_tick_i,
  input  wire logic       rtc_blink_i,
  input  wire logic       supply_fault_n_i,
  input  wire logic       accessory_float_flag_i,
  input  wire logic       wait_step_active_i,
  output logic      [7:0] wakeup_o,
  output logic      [7:0] general_input_o,
  output logic            system_enable_input_o,
  output logic            power_enable_input_o,
  output logic            secondary_power_enable_input_o,
  output logic            feedback_signal_one_o,
  output logic            regulator9_enable_o,
  output logic            wait_timeout_o,
  output logic            irq_o
);
  // overview of the block
  //
  // register side
  //   four settings registers hold two pins each, the lower pin in bits 3:0
  //   and the upper pin in bits 7:4; every bit reads back as written
  //   the event status register is sticky and cleared by writing ones
  //   the mask register has the same layout; a one hides that event
  //   the pin status register collects the enable and feedback levels,
  //   the regulator nine enable and the wait-step timeout
  //   read data stand for one cycle after the strobe and are zero otherwise,
  //   so a bus that ors several slaves together needs no extra gating
  //
  // pin side
  //   every pin input passes two flip-flops before anything reads it
  //   the debounced copy follows the synchronised level only after that
  //   level has stood unchanged for a fixed count of slow ticks
  //   polarity is applied after the optional debounce, so the filter sees
  //   the raw pin and a type change never restarts a running filter
  //   outputs are registered, so a new setting reaches the pin one cycle
  //   after the settings register itself has changed
  //
  // event side
  //   a wake-up pulse lasts one cycle and marks an inactive-to-active edge
  //   of a debounced input; pin eleven in its accessory function wakes on
  //   the falling edge of the float flag instead
  //   pin twelve as a regulator control input raises its event on any
  //   change, which software may mask to hide short interrupt pulses
  //
  // limitations
  //   the edge history runs on every cycle, also while a pin is an output,
  //   so turning a pin into an input never fires a stale edge
  //   the wait-step counter restarts whenever the step or the setting drops
  //   the timeout level stays high until the sequencer leaves its wait step
  //
  // hazards
  //   the settings reset to the alternate function on every pin, so the
  //   fault pin comes up as an open-drain driver of the fault level
  //   all other pins come up released, with no pull-up switched on
  //   a write to the status register and a new event in one cycle keep the
  //   event, so software never loses an edge that it did not see
  //
  // storage
  //   settings, status and mask are plain flip-flops
  //   the debounce counters are three bits per pin
  //   the wait-step counter is thirty-two bits wide so that the default
  //   half-second span at the system clock fits
  //
  // trade-offs
  //   one shared slow tick drives all filters, which keeps the counters
  //   small at the cost of a filter length that moves with that tick
  //   wake, irq and input-level outputs are combinational; pin drive, read data, regulator and timeout outputs come from flops
  //
  logic [7:0] cfg_r [4];
  logic [7:0] evt_r, mask_r;
  logic [7:0] sync1_r, sync2_r, deb_r, act_d_r;
  logic [2:0] deb_cnt_r [8];
  logic       float_s1_r, float_s2_r, float_d_r;
  logic [31:0] wait_cnt_r;
  logic [7:0] active, events;
  logic [7:0] pin_status;
  logic [3:0] pcfg [8];

  // pick the nibble for pin index k (0 means pin six)
  function automatic logic [3:0] nib(input int k, input logic [7:0] c);
    nib = (k % 2 == 0) ? c[3:0] : c[7:4];
  endfunction

  function automatic logic [3:0] cfg_of(input int k);
    cfg_of = nib(k, cfg_r[k/2]);
  endfunction

  // settings nibble of every pin, held in a signal so that fields can be sliced
  always_comb begin
    for (int i = 0; i < 8; i++) pcfg[i] = cfg_of(i);
  end

  // configuration writes, eight bit read-write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < 4; i++) cfg_r[i] <= mfp_pkg::CFG_RESET;
    end else if (wr_i && addr_i >= mfp_pkg::ADDR_CFG_67 && addr_i <= mfp_pkg::ADDR_CFG_1213) begin
      cfg_r[addr_i[1:0]] <= wdata_i;
    end
  end

  // two-flop synchronisers for pins and float flag; stage one read only by stage two
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r    <= 8'h00;
      sync2_r    <= 8'h00;
      float_s1_r <= 1'b0;
      float_s2_r <= 1'b0;
    end else begin
      sync1_r    <= pin_in_i;
      sync2_r    <= sync1_r;
      float_s1_r <= accessory_float_flag_i;
      float_s2_r <= float_s1_r;
    end
  end

  // debounce: the change is taken only after DEB_TICKS stable slow ticks
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deb_r <= 8'h00;
      for (int i = 0; i < 8; i++) deb_cnt_r[i] <= 3'h0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (sync2_r[i] == deb_r[i]) begin
          deb_cnt_r[i] <= 3'h0;
        end else if (slow_tick_i) begin
          if (deb_cnt_r[i] == mfp_pkg::DEB_TICKS_W - 3'h1) begin
            deb_r[i]     <= sync2_r[i];
            deb_cnt_r[i] <= 3'h0;
          end else begin
            deb_cnt_r[i] <= deb_cnt_r[i] + 3'h1;
          end
        end
      end
    end
  end

  // per-pin input level after polarity and optional debounce
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic [3:0] c;
      logic       raw;
      c          = cfg_of(i);
      raw        = c[mfp_pkg::FLD_MODE] ? deb_r[i] : sync2_r[i];
      // polarity: type 0 active low, type 1 active high
      active[i]  = c[mfp_pkg::FLD_TYPE] ? raw : ~raw;
    end
  end

  // wake-up pulses on an active edge of a debounced input pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic [3:0] c;
      logic       is_in;
      c     = cfg_of(i);
      is_in = (c[1:0] == mfp_pkg::FUNC_INPUT) || (c[1:0] == mfp_pkg::FUNC_ALT);
      events[i] = is_in && c[mfp_pkg::FLD_MODE] && active[i] && !act_d_r[i];
    end
    // pin eleven accessory detect: only the float flag falling edge wakes
    if (pcfg[5][1:0] == mfp_pkg::FUNC_ALT) begin
      events[5] = pcfg[5][mfp_pkg::FLD_MODE] && float_d_r && !float_s2_r;
    end
    // pin twelve as regulator control input, either mode: any level change wakes
    if (pcfg[6][1:0] == mfp_pkg::FUNC_INPUT) begin
      events[6] = (active[6] != act_d_r[6]);
    end
    // pin eight in mode 0 is a plain input and never wakes
    if (!pcfg[2][mfp_pkg::FLD_MODE]) events[2] = 1'b0;
    wakeup_o = events;
  end

  // edge history for active levels and float flag
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_d_r   <= 8'h00;
      float_d_r <= 1'b0;
    end else begin
      act_d_r   <= active;
      float_d_r <= float_s2_r;
    end
  end

  // alternate-function status bits from the enable and feedback pins
  always_comb begin
    system_enable_input_o = (pcfg[2][1:0] == mfp_pkg::FUNC_ALT)
                            && pcfg[2][mfp_pkg::FLD_MODE] && active[2];
    power_enable_input_o  = (pcfg[3][1:0] == mfp_pkg::FUNC_ALT) && active[3];
    secondary_power_enable_input_o =
      (pcfg[4][1:0] == mfp_pkg::FUNC_ALT) && active[4];
    feedback_signal_one_o = (pcfg[6][1:0] == mfp_pkg::FUNC_ALT) && active[6];
    general_input_o       = active;
  end

  // regulator nine follows pin twelve level in control mode 0, unfiltered
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      regulator9_enable_o <= 1'b0;
    end else if (pcfg[6][1:0] == mfp_pkg::FUNC_INPUT && !pcfg[6][mfp_pkg::FLD_MODE]) begin
      regulator9_enable_o <= active[6];
    end
  end

  // wait-step timeout for pin ten secondary enable in debounced mode
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_cnt_r     <= 32'h0;
      wait_timeout_o <= 1'b0;
    end else if (pcfg[4][1:0] == mfp_pkg::FUNC_ALT && pcfg[4][mfp_pkg::FLD_MODE]
                 && wait_step_active_i) begin
      if (wait_cnt_r == 32'(WAIT_TIMEOUT_CYC - 1)) begin
        wait_timeout_o <= 1'b1;
      end else begin
        wait_cnt_r <= wait_cnt_r + 32'h1;
      end
    end else begin
      wait_cnt_r     <= 32'h0;
      wait_timeout_o <= 1'b0;
    end
  end

  // pin drivers; the function field picks the driver style
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_o        <= 8'h00;
      pin_oe_n_o       <= 8'hff;
      pin_supply_two_o <= 8'h00;
      pin_pullup_en_o  <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        logic [3:0] c;
        logic       lvl;
        c   = cfg_of(i);
        lvl = c[mfp_pkg::FLD_MODE];
        if ((i == 4 || i == 5) && c[mfp_pkg::FLD_TYPE]) lvl = rtc_blink_i;
        if (i == 7 && c[1:0] == mfp_pkg::FUNC_ALT) lvl = supply_fault_n_i;
        pin_supply_two_o[i] <= c[mfp_pkg::FLD_TYPE];
        unique case (c[1:0])
          mfp_pkg::FUNC_PP: begin
            pin_out_o[i]       <= lvl;
            pin_oe_n_o[i]      <= 1'b0;
            pin_pullup_en_o[i] <= 1'b0;
          end
          mfp_pkg::FUNC_OD: begin
            pin_out_o[i]       <= 1'b0;
            pin_oe_n_o[i]      <= lvl; // release for high
            pin_pullup_en_o[i] <= ~c[mfp_pkg::FLD_TYPE];
          end
          mfp_pkg::FUNC_ALT: begin
            pin_out_o[i]       <= lvl;
            pin_oe_n_o[i]      <= (i == 7) ? lvl : 1'b1; // fault is open-drain low
            pin_pullup_en_o[i] <= (i == 7) && !c[mfp_pkg::FLD_TYPE];
          end
          default: begin
            pin_out_o[i]       <= 1'b0;
            pin_oe_n_o[i]      <= 1'b1;
            pin_pullup_en_o[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // sticky event status: set wins over write-one-to-clear
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_r  <= 8'h00;
      mask_r <= mfp_pkg::MASK_RESET;
    end else begin
      if (wr_i && addr_i == mfp_pkg::ADDR_EVT_MASK) mask_r <= wdata_i;
      if (wr_i && addr_i == mfp_pkg::ADDR_EVT_STATUS) evt_r <= (evt_r & ~wdata_i) | events;
      else evt_r <= evt_r | events;
    end
  end

  assign irq_o = |(evt_r & ~mask_r);

  // pin status word
  always_comb begin
    pin_status = 8'h00;
    pin_status[mfp_pkg::ST_SYSTEM_ENABLE_INPUT]  = system_enable_input_o;
    pin_status[mfp_pkg::ST_POWER_ENABLE_INPUT]  = power_enable_input_o;
    pin_status[mfp_pkg::ST_SECONDARY_POWER_ENABLE_INPUT] = secondary_power_enable_input_o;
    pin_status[mfp_pkg::ST_FB1]     = feedback_signal_one_o;
    pin_status[mfp_pkg::ST_REG9_EN] = regulator9_enable_o;
    pin_status[mfp_pkg::ST_WAIT_TO] = wait_timeout_o;
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        mfp_pkg::ADDR_CFG_67:     rdata_o <= cfg_r[0];
        mfp_pkg::ADDR_CFG_89:     rdata_o <= cfg_r[1];
        mfp_pkg::ADDR_CFG_1011:   rdata_o <= cfg_r[2];
        mfp_pkg::ADDR_CFG_1213:   rdata_o <= cfg_r[3];
        mfp_pkg::ADDR_EVT_STATUS: rdata_o <= evt_r;
        mfp_pkg::ADDR_EVT_MASK:   rdata_o <= mask_r;
        mfp_pkg::ADDR_PIN_STATUS: rdata_o <= pin_status;
        default:                  rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule // multi_function_pin_config

// file: testbench/mfp_props.sv
// checker: register port and pin-drive relations at the block ports
// assumes one clock domain; bound to every instance of the block
`timescale 1ns/10ps
module mfp_props (
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pin_out_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pin_supply_two_o,
  input wire logic [7:0] wakeup_o,
  input wire logic       wait_step_active_i,
  input wire logic       wait_timeout_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero after idle cycle");
  cfg_rdback_a: assert property (wr_i && addr_i == 8'h19 ##1 rd_i && addr_i == 8'h19
    |=> rdata_o == $past(wdata_i, 2)) else $error("config read back mismatch");
  unmapped_rd_a: assert property (rd_i && addr_i == 8'h40 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  pp_drive_a: assert property (wr_i && addr_i == 8'h18 && wdata_i[3:0] == 4'hf
    |-> ##[1:2] (pin_out_o[0] && !pin_oe_n_o[0] && pin_supply_two_o[0]))
    else $error("push-pull high not driven");
  wake_pulse_a: assert property (wakeup_o != 8'h00
    |=> (wakeup_o & $past(wakeup_o)) == 8'h00) else $error("wake pulse too long");
  wait_cause_a: assert property ($rose(wait_timeout_o) |-> $past(wait_step_active_i))
    else $error("timeout outside wait step");
  irq_mask_a: assert property (wr_i && addr_i == mfp_pkg::ADDR_EVT_MASK
    && wdata_i == 8'hff |-> ##2 !irq_o) else $error("irq high with all masked");
  oe_reset_a: assert property ($rose(resetn_i) |-> pin_oe_n_o == 8'hff)
    else $error("pin driven out of reset");
endmodule // mfp_props

bind multi_function_pin_config mfp_props u_props (.clk_sys_i, .resetn_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_out_o, .pin_oe_n_o, .pin_supply_two_o,
  .wakeup_o, .wait_step_active_i, .wait_timeout_o, .irq_o);

// file: testbench/mfp_pin_model.sv
// far-side pin model: external drivers and pull-ups on eight pins
// assumes the testbench chooses which pins the far side drives
`timescale 1ns/10ps
module mfp_pin_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] lvl_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_lvl_i,
  output logic      [7:0] pin_o
);
  logic [7:0] float_r = 8'h5a;
  // an undriven line changes every cycle so no stale level is read
  always @(posedge clk_sys_i) float_r <= ~float_r;
  // device drive wins, then the far side, then the pull-up
  assign pin_o = (~oe_n_i & lvl_i) | (oe_n_i & ext_en_i & ext_lvl_i)
               | (oe_n_i & ~ext_en_i & (pullup_i | float_r));
endmodule // mfp_pin_model

// file: testbench/multi_function_pin_config_tb.sv
// testbench: registers, pin modes, special pin functions and events
// assumes the pin model on the far side and a 100 MHz clock
`timescale 1ns/10ps
module multi_function_pin_config_tb;
  logic       clk_sys_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic       slow_tick_i = 1'b0, rtc_blink_i = 1'b0, supply_fault_n_i = 1'b1;
  logic       accessory_float_flag_i = 1'b1, wait_step_active_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, ext_lvl = 8'hff, ext_en = 8'hff;
  logic [7:0] rdata_o, pin_in_i, pin_out_o, pin_oe_n_o, pin_supply_two_o, pin_pullup_en_o;
  logic [7:0] wakeup_o, general_input_o;
  logic       system_enable_input_o, power_enable_input_o, secondary_power_enable_input_o;
  logic       feedback_signal_one_o, regulator9_enable_o, wait_timeout_o, irq_o;
  int         failures = 0, checked = 0, wakes = 0, w0;
  wire [7:0]  p6 = {4'h0, pin_supply_two_o[0], pin_pullup_en_o[0], pin_oe_n_o[0], pin_out_o[0]};
  always #5 clk_sys_i = ~clk_sys_i;
  // a tick every other cycle keeps debounce runs short
  always @(posedge clk_sys_i) slow_tick_i <= ~slow_tick_i;
  // wake pulses last one cycle, so they are counted as they pass
  always @(posedge clk_sys_i) wakes <= wakes + $countones(wakeup_o);
  multi_function_pin_config #(.WAIT_TIMEOUT_CYC(20)) u_dut (.*);
  mfp_pin_model u_pins (.clk_sys_i, .lvl_i(pin_out_o), .oe_n_i(pin_oe_n_o),
    .pullup_i(pin_pullup_en_o), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl), .pin_o(pin_in_i));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // one-cycle write strobe, then an idle cycle so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
    cyc(1);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr_i <= a;
    rd_i <= 1'b1;
    cyc(1);
    rd_i <= 1'b0;
    #1 check(what, rdata_o, exp);
    cyc(1);
  endtask
  task automatic s_regs();
    for (int i = 0; i < 4; i++)
      rd(8'h18 + 8'(i), mfp_pkg::CFG_RESET, "cfg reset");
    rd(8'h40, 8'h00, "unmapped");
    addr_i <= 8'h19;
    wdata_i <= 8'ha5;
    wr_i <= 1'b1;
    cyc(1);
    wr_i <= 1'b0;
    rd(8'h19, 8'ha5, "cfg89");
  endtask
  task automatic s_pins();
    logic [7:0] cf[5] = '{8'h02, 8'h0a, 8'h03, 8'h0f, 8'h06};
    logic [7:0] ex[5] = '{8'h04, 8'h06, 8'h00, 8'h09, 8'h08};
    wr(8'h18, 8'h01);
    ext_lvl[0] <= 1'b0;
    cyc(4);
    check("gi low", general_input_o & 8'h01, 8'h01);
    wr(8'h18, 8'h05);
    cyc(4);
    check("gi high", general_input_o & 8'h01, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'h18, cf[i]);
      cyc(2);
      check("drive", p6 & (i == 1 ? 8'hfe : 8'hff), ex[i]);
    end
    ext_lvl[0] <= 1'b1;
    wr(8'h18, 8'h09);
    cyc(20);
    w0 = wakes;
    ext_lvl[0] <= 1'b0;
    cyc(4);
    check("deb early", general_input_o & 8'h01, 8'h00);
    cyc(20);
    check("deb late", general_input_o & 8'h01, 8'h01);
    check("wake", 8'(wakes - w0), 8'h01);
    wr(8'h18, 8'h01);
    ext_lvl[0] <= 1'b1;
    cyc(4);
    w0 = wakes;
    ext_lvl[0] <= 1'b0;
    cyc(4);
    check("no wake", {7'h00, general_input_o[0]} | 8'(wakes - w0) << 1, 8'h01);
  endtask
  task automatic s_enables();
    ext_lvl[3:2] <= 2'b01;
    wr(8'h19, 8'h0c);
    cyc(24);
    check("sys pwr", {6'h00, system_enable_input_o, power_enable_input_o}, 8'h03);
    wr(8'h19, 8'h04);
    cyc(4);
    check("sys off", {6'h00, system_enable_input_o, general_input_o[2]}, 8'h01);
  endtask
  task automatic s_reg9();
    wr(8'h1b, 8'h00);
    supply_fault_n_i <= 1'b0;
    ext_lvl[6] <= 1'b0;
    cyc(4);
    check("fault fb", {5'h00, feedback_signal_one_o, pin_oe_n_o[7], pin_pullup_en_o[7]}, 8'h05);
    supply_fault_n_i <= 1'b1;
    wr(mfp_pkg::ADDR_EVT_MASK, 8'hbf);
    ext_lvl[6] <= 1'b0;
    wr(8'h1b, 8'h05);
    cyc(4);
    wr(mfp_pkg::ADDR_EVT_STATUS, 8'hff);
    ext_lvl[6] <= 1'b1;
    cyc(4);
    check("reg9 on", {6'h00, regulator9_enable_o, irq_o}, 8'h03);
    wr(mfp_pkg::ADDR_EVT_STATUS, 8'h40);
    check("irq clr", {7'h00, irq_o}, 8'h00);
    ext_lvl[6] <= 1'b0;
    cyc(4);
    check("reg9 off", {6'h00, regulator9_enable_o, irq_o}, 8'h01);
    wr(8'h1b, 8'h0d);
    ext_lvl[6] <= 1'b1;
    cyc(20);
    check("reg9 deb", {7'h00, regulator9_enable_o}, 8'h00);
    wr(mfp_pkg::ADDR_EVT_MASK, 8'hff);
    check("irq mask", {7'h00, irq_o}, 8'h00);
  endtask
  task automatic s_wait_blink();
    wr(8'h1a, 8'h88);
    cyc(20);
    w0 = wakes;
    accessory_float_flag_i <= 1'b0;
    wait_step_active_i <= 1'b1;
    cyc(12);
    check("to early", {7'h00, wait_timeout_o}, 8'h00);
    cyc(30);
    check("to late", {7'h00, wait_timeout_o}, 8'h01);
    rd(mfp_pkg::ADDR_PIN_STATUS, 8'h22, "pin status");
    accessory_float_flag_i <= 1'b1;
    wait_step_active_i <= 1'b0;
    cyc(20);
    check("acc wake", 8'(wakes - w0), 8'h01);
    wr(8'h1a, 8'h07);
    rtc_blink_i <= 1'b1;
    cyc(4);
    check("blink hi", pin_out_o & 8'h10, 8'h10);
    rtc_blink_i <= 1'b0;
    cyc(4);
    check("blink lo", pin_out_o & 8'h10, 8'h00);
  endtask
  initial begin
    cyc(12);
    resetn_i <= 1'b1;
    cyc(1);
    s_regs();
    s_pins();
    s_enables();
    s_reg9();
    s_wait_blink();
    stop_test();
  end
  // watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    cyc(5000);
    failures++;
    stop_test();
  end
endmodule // multi_function_pin_config_tb
